// ===== hw/lmx_defs.vh
// constants for the literal, move, indirect and return execution block
`ifndef LMX_DEFS_VH
`define LMX_DEFS_VH

// ==========================================================
// opcode patterns (14-bit instruction word)
`define LMX_OP_IDLE        14'h0000
`define LMX_OP_RESET       14'h0001
`define LMX_OP_RETFI       14'h0009
`define LMX_OP_STIND_HI    11'h003
`define LMX_OP_STREL_HI    7'h7F
`define LMX_OP_BANK_HI     8'h01
`define LMX_OP_WORK_HI     6'h30
`define LMX_OP_PAGE_HI     7'h63
`define LMX_OP_STFILE_HI   7'h01

// ==========================================================
// pointer mode codes
`define LMX_MODE_PREINC    2'h0
`define LMX_MODE_PREDEC    2'h1
`define LMX_MODE_POSTINC   2'h2
`define LMX_MODE_POSTDEC   2'h3

// ==========================================================
// register layout and reset values
`define LMX_GIE_BIT        7
`define LMX_SOFTRST_BIT    2
`define LMX_IRQCTL_RESET   8'h00
`define LMX_PWRCTL_RESET   8'h0F
`define LMX_FSR_RESET      16'h0000
`define LMX_BANK_RESET     6'h00
`define LMX_PAGE_RESET     7'h00
`define LMX_WORK_RESET     8'h00
`define LMX_PC_RESET       15'h0000

`endif

// ===== hw/lmx_exec.v
// execution unit for literal loads, stores, idle, software reset and interrupt return
// Overview of operation
// - bank literal load writes 6-bit operand to bank select; flags unchanged
// - page literal load writes 7-bit operand to pc high latch; flags unchanged
// - work literal load puts 8-bit operand in working register in one cycle
// - store to file writes working register to 7-bit addressed file register
// - indirect address is pointer+1, pointer-1, the pointer itself (post modes), or pointer plus signed offset
// - mode code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// - pointer ends at +1 for increments, -1 for decrements, unchanged for relative
// - one-bit index picks pointer; indirect port accesses the pointed location
// - pointers are 16-bit and wrap at both ends
// - pointer updates never touch status flags
// - software reset causes full device reset and clears soft reset flag
// - interrupt return pops stack to pc and sets global enable, two cycles
`timescale 1ns/10ps
`include "lmx_defs.vh"

module lmx_exec (
  input  wire        CLK,
  input  wire        RESET,
  input  wire        INSTR_VALID,
  input  wire [13:0] INSTR,
  input  wire [14:0] STACK_TOP,
  input  wire        FSR0_WRITE,
  input  wire        FSR1_WRITE,
  input  wire [15:0] FSR_WDATA,
  output reg  [5:0]  BANK_SELECT_REG,
  output reg  [6:0]  PC_HIGH_LATCH,
  output reg  [7:0]  WORK_REG,
  output reg  [7:0]  IRQ_CONTROL_REG,
  output reg  [7:0]  POWER_CONTROL_REG,
  output reg  [14:0] PC,
  output wire [15:0] FILE_SELECT_POINTER0,
  output wire [15:0] FILE_SELECT_POINTER1,
  output reg         MEM_WRITE,
  output reg  [15:0] MEM_ADDR,
  output reg  [7:0]  MEM_WDATA,
  output reg         STACK_POP,
  output wire        FLUSH_PREFETCH,
  output reg         DEVICE_RESET_REQ
);

  // ==========================================================
  // states
  localparam [1:0] ST_RUN   = 2'b01;
  localparam [1:0] ST_FLUSH = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  wire        live = INSTR_VALID && (state == ST_RUN);

  // ==========================================================
  // decode
  wire is_idle   = live && (INSTR == `LMX_OP_IDLE);
  wire is_reset  = live && (INSTR == `LMX_OP_RESET);
  wire is_retfi  = live && (INSTR == `LMX_OP_RETFI);
  wire is_stind  = live && (INSTR[13:3] == `LMX_OP_STIND_HI);
  wire is_strel  = live && (INSTR[13:7] == `LMX_OP_STREL_HI);
  wire is_bank   = live && (INSTR[13:6] == `LMX_OP_BANK_HI);
  wire is_page   = live && (INSTR[13:7] == `LMX_OP_PAGE_HI);
  wire is_work   = live && (INSTR[13:8] == `LMX_OP_WORK_HI);
  wire is_stfile = live && (INSTR[13:7] == `LMX_OP_STFILE_HI);

  // pointer index: bit 2 for mode form, bit 6 for relative form
  wire        sel_idx  = is_strel ? INSTR[6] : INSTR[2];
  wire [1:0]  mode     = INSTR[1:0];
  wire [5:0]  offset   = INSTR[5:0];
  wire [15:0] addr0;
  wire [15:0] addr1;

  // ==========================================================
  // two pointers, selected by the one-bit index
  lmx_ptr_unit u_ptr0 (
    .CLK        (CLK),
    .RESET      (RESET),
    .sel        (~sel_idx),
    .do_mode    (is_stind),
    .do_rel     (is_strel),
    .mode       (mode),
    .offset     (offset),
    .load       (FSR0_WRITE),
    .load_value (FSR_WDATA),
    .value      (FILE_SELECT_POINTER0),
    .addr       (addr0)
  );

  lmx_ptr_unit u_ptr1 (
    .CLK        (CLK),
    .RESET      (RESET),
    .sel        (sel_idx),
    .do_mode    (is_stind),
    .do_rel     (is_strel),
    .mode       (mode),
    .offset     (offset),
    .load       (FSR1_WRITE),
    .load_value (FSR_WDATA),
    .value      (FILE_SELECT_POINTER1),
    .addr       (addr1)
  );

  // ==========================================================
  // flush sequencing for two-cycle instructions
  always @* begin
    case (state)
      ST_RUN:   next_state = is_retfi ? ST_FLUSH : ST_RUN;
      ST_FLUSH: next_state = ST_RUN;
      default:  next_state = ST_RUN;
    endcase
  end

  assign FLUSH_PREFETCH = is_retfi;

  always @(posedge CLK) begin
    if (RESET) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // next values of the architectural registers
  // no status flags live in this block, so no instruction here, pointer
  // steps included, can disturb zero or carry
  localparam [7:0] PWR_RESET_VALUE = `LMX_PWRCTL_RESET;

  reg [5:0]  next_bank;
  reg [6:0]  next_page;
  reg [7:0]  next_work;
  reg [14:0] next_pc;
  reg [7:0]  next_irq_control;
  reg        next_mem_write;
  reg [15:0] next_mem_addr;
  reg [7:0]  next_mem_wdata;
  reg        next_stack_pop;
  reg        next_reset_req;
  reg        next_soft_flag;
  reg        soft_flag;

  // ==========================================================
  // literal loads
  always @* begin
    next_bank = BANK_SELECT_REG;
    if (is_bank) begin
      next_bank = INSTR[5:0];
    end
  end

  always @* begin
    next_page = PC_HIGH_LATCH;
    if (is_page) begin
      next_page = INSTR[6:0];
    end
  end

  // one word, one cycle: the value is visible right after the taking edge
  always @* begin
    next_work = WORK_REG;
    if (is_work) begin
      next_work = INSTR[7:0];
    end
  end

  // ==========================================================
  // program counter
  // interrupt return loads the popped address; in the flush cycle after it
  // live is low, so the counter waits and the prefetched word is lost
  always @* begin
    next_pc = PC;
    if (is_retfi) begin
      next_pc = STACK_TOP;
    end else if (live) begin
      next_pc = PC + 15'h0001;
    end
  end

  // ==========================================================
  // interrupt control and stack
  // only the global enable is touched; the other bits belong elsewhere
  always @* begin
    next_irq_control = IRQ_CONTROL_REG;
    if (is_retfi) begin
      next_irq_control[`LMX_GIE_BIT] = 1'b1;
    end
  end

  always @* begin
    next_stack_pop = is_retfi;
  end

  // ==========================================================
  // data memory write port
  // the indirect port has no storage: its write goes to the pointed address
  always @* begin
    next_mem_write = 1'b0;
    next_mem_addr  = MEM_ADDR;
    next_mem_wdata = MEM_WDATA;
    if (is_stfile) begin
      next_mem_write = 1'b1;
      next_mem_addr  = {9'h000, INSTR[6:0]};
      next_mem_wdata = WORK_REG;
    end else if (is_stind || is_strel) begin
      next_mem_write = 1'b1;
      next_mem_addr  = sel_idx ? addr1 : addr0;
      next_mem_wdata = WORK_REG;
    end
  end

  // ==========================================================
  // software reset
  // the request goes out for one cycle; the system turns it into RESET
  always @* begin
    next_reset_req = is_reset;
  end

  // the flag has no RESET branch: the device reset that the request causes
  // must not set it again, so only power-up gives it its value
  always @* begin
    next_soft_flag = soft_flag;
    if (is_reset) begin
      next_soft_flag = 1'b0;
    end
  end

  // ==========================================================
  // register updates
  always @(posedge CLK) begin
    if (RESET) begin
      BANK_SELECT_REG <= `LMX_BANK_RESET;
      PC_HIGH_LATCH   <= `LMX_PAGE_RESET;
      WORK_REG        <= `LMX_WORK_RESET;
    end else begin
      BANK_SELECT_REG <= next_bank;
      PC_HIGH_LATCH   <= next_page;
      WORK_REG        <= next_work;
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      PC              <= `LMX_PC_RESET;
      IRQ_CONTROL_REG <= `LMX_IRQCTL_RESET;
      STACK_POP       <= 1'b0;
    end else begin
      PC              <= next_pc;
      IRQ_CONTROL_REG <= next_irq_control;
      STACK_POP       <= next_stack_pop;
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      MEM_WRITE <= 1'b0;
      MEM_ADDR  <= 16'h0000;
      MEM_WDATA <= 8'h00;
    end else begin
      MEM_WRITE <= next_mem_write;
      MEM_ADDR  <= next_mem_addr;
      MEM_WDATA <= next_mem_wdata;
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      DEVICE_RESET_REQ <= 1'b0;
    end else begin
      DEVICE_RESET_REQ <= next_reset_req;
    end
  end

  // ==========================================================
  // power control view
  // a reset instruction seen while RESET is high is dropped with the rest
  always @(posedge CLK) begin
    if (!RESET) begin
      soft_flag <= next_soft_flag;
    end
  end

  // power-up value; there is no power-on input, so this relies on
  // register initialisation at configuration
  initial begin
    soft_flag = PWR_RESET_VALUE[`LMX_SOFTRST_BIT];
  end

  // the other bits are held at their reset value
  always @* begin
    POWER_CONTROL_REG                   = PWR_RESET_VALUE;
    POWER_CONTROL_REG[`LMX_SOFTRST_BIT] = soft_flag;
  end

endmodule

// ===== hw/lmx_ptr_unit.v
// one file-select pointer with address forming and update
`timescale 1ns/10ps
`include "lmx_defs.vh"

module lmx_ptr_unit (
  input  wire        CLK,
  input  wire        RESET,
  input  wire        sel,
  input  wire        do_mode,
  input  wire        do_rel,
  input  wire [1:0]  mode,
  input  wire [5:0]  offset,
  input  wire        load,
  input  wire [15:0] load_value,
  output reg  [15:0] value,
  output reg  [15:0] addr
);

  reg [15:0] next_value;

  // ==========================================================
  // address forming, wraps modulo 2^16
  always @* begin
    case (mode)
      `LMX_MODE_PREINC:  addr = value + 16'h0001;
      `LMX_MODE_PREDEC:  addr = value - 16'h0001;
      default:           addr = value;
    endcase
    if (do_rel) begin
      addr = value + {{10{offset[5]}}, offset};
    end
  end

  // ==========================================================
  // pointer update
  always @* begin
    next_value = value;
    if (load) begin
      next_value = load_value;
    end else if (sel && do_mode) begin
      if (mode[0]) begin
        next_value = value - 16'h0001;
      end else begin
        next_value = value + 16'h0001;
      end
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      value <= `LMX_FSR_RESET;
    end else begin
      value <= next_value;
    end
  end

endmodule

// ===== tb/lmx_exec_chk.sv
// concurrent checks on the execution unit ports
`timescale 1ns/10ps
`include "lmx_defs.vh"
module lmx_exec_chk (
  input wire        CLK,
  input wire        RESET,
  input wire        INSTR_VALID,
  input wire [13:0] INSTR,
  input wire [14:0] STACK_TOP,
  input wire        FSR0_WRITE,
  input wire [5:0]  BANK_SELECT_REG,
  input wire [6:0]  PC_HIGH_LATCH,
  input wire [7:0]  WORK_REG,
  input wire [7:0]  IRQ_CONTROL_REG,
  input wire [7:0]  POWER_CONTROL_REG,
  input wire [14:0] PC,
  input wire [15:0] FILE_SELECT_POINTER0,
  input wire        MEM_WRITE,
  input wire [15:0] MEM_ADDR,
  input wire [7:0]  MEM_WDATA,
  input wire        STACK_POP,
  input wire        FLUSH_PREFETCH,
  input wire        DEVICE_RESET_REQ
);
  // ==========
  // decode helpers
  reg fl;
  wire [13:0] i = INSTR;
  wire ok = INSTR_VALID && !fl && !RESET;
  wire ind = ok && i[13:3] == 11'h003 && !i[2] && !FSR0_WRITE;
  wire rel = ok && i[13:7] == `LMX_OP_STREL_HI && !i[6] && !FSR0_WRITE;
  always @(posedge CLK) fl <= RESET ? 1'b0 : FLUSH_PREFETCH;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ==========
  // assertions
  bank_load_a: assert property (ok && i[13:6] == `LMX_OP_BANK_HI
    |=> BANK_SELECT_REG == $past(i[5:0])) else $error("bank load wrong");
  page_load_a: assert property (ok && i[13:7] == `LMX_OP_PAGE_HI
    |=> PC_HIGH_LATCH == $past(i[6:0])) else $error("page load wrong");
  work_load_a: assert property (ok && i[13:8] == `LMX_OP_WORK_HI
    |=> WORK_REG == $past(i[7:0])) else $error("work load wrong");
  file_store_a: assert property (ok && i[13:7] == `LMX_OP_STFILE_HI |=> MEM_WRITE
    && MEM_WDATA == $past(WORK_REG) && MEM_ADDR[6:0] == $past(i[6:0]))
    else $error("file store wrong");
  ind_addr_a: assert property (ind |=> MEM_WRITE && MEM_ADDR ==
    ($past(i[1]) ? $past(FILE_SELECT_POINTER0) : FILE_SELECT_POINTER0))
    else $error("indirect address wrong");
  ptr_step_a: assert property (ind |=> FILE_SELECT_POINTER0 ==
    $past(FILE_SELECT_POINTER0) + ($past(i[0]) ? 16'hFFFF : 16'h0001))
    else $error("pointer step wrong");
  rel_addr_a: assert property (rel |=> FILE_SELECT_POINTER0 == $past(FILE_SELECT_POINTER0)
    && MEM_ADDR == $past(FILE_SELECT_POINTER0) + {{10{$past(i[5])}}, $past(i[5:0])})
    else $error("relative address wrong");
  soft_reset_a: assert property (ok && i == `LMX_OP_RESET |=> DEVICE_RESET_REQ
    && !POWER_CONTROL_REG[`LMX_SOFTRST_BIT]) else $error("soft reset wrong");
  irq_return_a: assert property (ok && i == `LMX_OP_RETFI |-> FLUSH_PREFETCH ##1
    (PC == $past(STACK_TOP) && STACK_POP && IRQ_CONTROL_REG[`LMX_GIE_BIT]))
    else $error("interrupt return wrong");
  idle_step_a: assert property (ok && i == `LMX_OP_IDLE |=> PC == $past(PC) + 15'h0001
    && !MEM_WRITE && $stable(WORK_REG)) else $error("idle changed state");
  flush_skip_a: assert property (fl |=> !MEM_WRITE && $stable(WORK_REG))
    else $error("flushed word executed");
  cover property (ind);
  cover property (rel);
  cover property (ok && i == `LMX_OP_RETFI);
endmodule
bind lmx_exec lmx_exec_chk lmx_exec_chk_inst (.*);

// ===== tb/lmx_exec_tb_top.sv
// self-checking bench for the execution unit
`timescale 1ns/10ps
`include "lmx_defs.vh"
module lmx_exec_tb_top;
  reg CLK = 0, RESET = 1, INSTR_VALID = 0, FSR0_WRITE = 0, FSR1_WRITE = 0;
  reg [13:0] INSTR = 0;
  reg [14:0] STACK_TOP = 0;
  reg [15:0] FSR_WDATA = 0, p, q;
  reg [1:0] m;
  wire [5:0] BANK_SELECT_REG;
  wire [6:0] PC_HIGH_LATCH;
  wire [7:0] WORK_REG, IRQ_CONTROL_REG, POWER_CONTROL_REG, MEM_WDATA;
  wire [14:0] PC;
  wire [15:0] FILE_SELECT_POINTER0, FILE_SELECT_POINTER1, MEM_ADDR;
  wire MEM_WRITE, STACK_POP, FLUSH_PREFETCH, DEVICE_RESET_REQ;
  integer errors = 0, n_tests = 0, j;
  always #10 CLK = ~CLK;
  lmx_exec lmx_exec_inst (.*);
  // ==========
  // shared tasks
  task chk(input [63:0] nm, input [15:0] exp, input [15:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // word is taken at the second edge, results checked just after it
  task ex(input [13:0] w);
    begin
      @(posedge CLK);
      INSTR <= w;
      INSTR_VALID <= 1'b1;
      @(posedge CLK);
      INSTR_VALID <= 1'b0;
      #1;
    end
  endtask
  task setp(input n, input [15:0] v);
    begin
      @(posedge CLK);
      FSR_WDATA <= v;
      FSR0_WRITE <= !n;
      FSR1_WRITE <= n;
      @(posedge CLK);
      FSR0_WRITE <= 1'b0;
      FSR1_WRITE <= 1'b0;
    end
  endtask
  // ==========
  // scenarios
  task t_lit;
    begin
      ex({`LMX_OP_BANK_HI, 6'h3F});
      chk("bank", 16'h003F, BANK_SELECT_REG);
      ex({`LMX_OP_PAGE_HI, 7'h7F});
      chk("page", 16'h007F, PC_HIGH_LATCH);
      ex({`LMX_OP_WORK_HI, 8'h5A});
      chk("work", 16'h005A, WORK_REG);
      ex({`LMX_OP_STFILE_HI, 7'h7F});
      chk("wr", 16'h0001, MEM_WRITE);
      chk("data", 16'h005A, MEM_WDATA);
      chk("faddr", 16'h007F, MEM_ADDR);
    end
  endtask
  // each mode starts at the edge that wraps, both pointers used
  task t_ind;
    begin
      for (j = 0; j < 4; j = j + 1) begin
        m = j[1:0];
        p = m[0] ? 16'h0000 : 16'hFFFF;
        q = m[0] ? p - 16'h0001 : p + 16'h0001;
        setp(m[1], p);
        ex({11'h003, m[1], m});
        chk("iaddr", m[1] ? p : q, MEM_ADDR);
        chk("ptr", q, m[1] ? FILE_SELECT_POINTER1 : FILE_SELECT_POINTER0);
      end
    end
  endtask
  task t_rel;
    begin
      setp(1'b1, 16'h0010);
      ex({`LMX_OP_STREL_HI, 1'b1, 6'h20});
      chk("raddr", 16'hFFF0, MEM_ADDR);
      chk("rptr", 16'h0010, FILE_SELECT_POINTER1);
      ex({`LMX_OP_STREL_HI, 1'b1, 6'h1F});
      chk("raddr", 16'h002F, MEM_ADDR);
      setp(1'b0, 16'hFFF0);
      ex({`LMX_OP_STREL_HI, 1'b0, 6'h1F});
      chk("raddr", 16'h000F, MEM_ADDR);
      chk("rptr", 16'hFFF0, FILE_SELECT_POINTER0);
    end
  endtask
  task t_idle;
    begin
      p = {1'b0, PC};
      ex(`LMX_OP_IDLE);
      chk("pc", p + 16'h0001, {1'b0, PC});
      chk("wr", 16'h0000, MEM_WRITE);
      chk("work", 16'h005A, WORK_REG);
    end
  endtask
  task t_ret;
    begin
      @(posedge CLK);
      STACK_TOP <= 15'h1234;
      INSTR <= `LMX_OP_RETFI;
      INSTR_VALID <= 1'b1;
      #1 chk("flush", 16'h0001, FLUSH_PREFETCH);
      @(posedge CLK);
      INSTR <= {`LMX_OP_WORK_HI, 8'h77};
      #1 chk("pc", 16'h1234, {1'b0, PC});
      chk("pop", 16'h0001, STACK_POP);
      chk("gie", 16'h0001, IRQ_CONTROL_REG[`LMX_GIE_BIT]);
      @(posedge CLK);
      INSTR_VALID <= 1'b0;
      #1 chk("work", 16'h005A, WORK_REG);
      chk("pc", 16'h1234, {1'b0, PC});
    end
  endtask
  task t_rst;
    begin
      chk("sflag", 16'h0001, POWER_CONTROL_REG[`LMX_SOFTRST_BIT]);
      ex(`LMX_OP_RESET);
      chk("rstreq", 16'h0001, DEVICE_RESET_REQ);
      chk("sflag", 16'h0000, POWER_CONTROL_REG[`LMX_SOFTRST_BIT]);
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // ==========
  // sequence and watchdog
  initial begin
    #20000;
    errors = errors + 1;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    t_lit;
    t_ind;
    t_rel;
    t_idle;
    t_ret;
    t_rst;
    report_and_stop;
  end
endmodule
